/* File: ofm_output_port.sv */
// Notes on behaviour
// - Each pin outputs its bit of the output level register, 0 low, 1 high.
// - Reading the output level register returns the written value, not pins.
// - Drive code per pin: 00 off, 01 P open drain, 10 N open drain, 11 CMOS.
// - Both drive-mode registers reset to zero, all pins high impedance.
// - Pin 3 function: 00 general output, 10 timer B; 01 and 11 prohibited.
// - Pin 2 function: 00 general output, 10 timer nine; 01 and 11 prohibited.
// - Pin 1 function: 00 general output, 01 fast clock, 10 PWM B; 11 prohibited.
// - Pin 0 function: 00 general output, 01 slow clock, 10 PWM A; 11 prohibited.
// - Port is output only, with no direction register.
// - Low drive-mode register takes 8-bit or 16-bit access covering the high one.
// - Both function-select registers reset to zero, all pins general output.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module ofm_output_port
  import ofm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Peripheral sources
  input wire logic slow_clock_in,
  input wire logic fast_clock_in,
  input wire logic timer_nine_in,
  input wire logic timer_b_in,
  input wire logic pwm_channel_a_in,
  input wire logic pwm_channel_b_in,
  // Pads
  output logic [3:0] pin_level_out,
  output logic [3:0] pin_oe_out
);

  logic [3:0] level_reg;
  logic [3:0] level_next;
  logic [3:0] drive_lo_reg;
  logic [3:0] drive_lo_next;
  logic [3:0] drive_hi_reg;
  logic [3:0] drive_hi_next;
  logic [3:0] func_lo_reg;
  logic [3:0] func_lo_next;
  logic [3:0] func_hi_reg;
  logic [3:0] func_hi_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic setup_phase;
  logic access_phase;
  logic wr_lane0;
  logic wr_lane1;
  ofm_sel_t sel;
  logic [3:0] pin_src;

  // Register read view: narrow data in low lane
  function automatic logic [DATA_W-1:0] read_view(input ofm_sel_t s);
    logic [DATA_W-1:0] v;
    v = RST_RDATA;
    case (s)
      SEL_LEVEL: v[FIELD_MSB:FIELD_LSB] = level_reg;
      SEL_DRIVE_LO: begin
        v[FIELD_MSB:FIELD_LSB] = drive_lo_reg;
        v[HI_LANE_MSB:HI_LANE_LSB] = drive_hi_reg;
      end
      SEL_DRIVE_HI: v[FIELD_MSB:FIELD_LSB] = drive_hi_reg;
      SEL_FUNC_LO: v[FIELD_MSB:FIELD_LSB] = func_lo_reg;
      SEL_FUNC_HI: v[FIELD_MSB:FIELD_LSB] = func_hi_reg;
      default: v = RST_RDATA;
    endcase
    return v;
  endfunction : read_view

  // Bus decode and register next values
  always_comb begin
    setup_phase = psel_in && !penable_in;
    access_phase = psel_in && penable_in;
    sel = ofm_decode(paddr_in);
    wr_lane0 = access_phase && pwrite_in && pstrb_in[0];
    wr_lane1 = access_phase && pwrite_in && pstrb_in[1];
    level_next = level_reg;
    drive_lo_next = drive_lo_reg;
    drive_hi_next = drive_hi_reg;
    func_lo_next = func_lo_reg;
    func_hi_next = func_hi_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (wr_lane0) begin
      case (sel)
        SEL_LEVEL: level_next = pwdata_in[FIELD_MSB:FIELD_LSB];
        SEL_DRIVE_LO: drive_lo_next = pwdata_in[FIELD_MSB:FIELD_LSB];
        SEL_DRIVE_HI: drive_hi_next = pwdata_in[FIELD_MSB:FIELD_LSB];
        SEL_FUNC_LO: func_lo_next = pwdata_in[FIELD_MSB:FIELD_LSB];
        SEL_FUNC_HI: func_hi_next = pwdata_in[FIELD_MSB:FIELD_LSB];
        default: level_next = level_reg;
      endcase
    end
    if (wr_lane1 && sel == SEL_DRIVE_LO) begin
      drive_hi_next = pwdata_in[HI_LANE_MSB:HI_LANE_LSB];
    end
    if (setup_phase) begin
      prdata_next = pwrite_in ? RST_RDATA : read_view(sel);
      pslverr_next = (sel == SEL_NONE);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      level_reg <= RST_LEVEL;
      drive_lo_reg <= RST_DRIVE;
      drive_hi_reg <= RST_DRIVE;
      func_lo_reg <= RST_FUNC;
      func_hi_reg <= RST_FUNC;
      prdata_reg <= RST_RDATA;
      pslverr_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      drive_lo_reg <= drive_lo_next;
      drive_hi_reg <= drive_hi_next;
      func_lo_reg <= func_lo_next;
      func_hi_reg <= func_hi_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Zero wait state; answer prepared during setup
  assign pready_out = 1'b1;
  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg && access_phase;

  ofm_func_mux u_func_mux (
    .func_lo_in(func_lo_reg),
    .func_hi_in(func_hi_reg),
    .level_in(level_reg),
    .slow_clock_in(slow_clock_in),
    .fast_clock_in(fast_clock_in),
    .timer_nine_in(timer_nine_in),
    .timer_b_in(timer_b_in),
    .pwm_channel_a_in(pwm_channel_a_in),
    .pwm_channel_b_in(pwm_channel_b_in),
    .pin_src_out(pin_src)
  );

  ofm_pin_stage u_pin_stage (
    .drive_lo_in(drive_lo_reg),
    .drive_hi_in(drive_hi_reg),
    .pin_src_in(pin_src),
    .pin_level_out(pin_level_out),
    .pin_oe_out(pin_oe_out)
  );

  // Checking helpers
  logic [3:0] cmos_gpio_mask;
  logic [3:0] hiz_mask;
  logic [3:0] nod_mask;
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      cmos_gpio_mask[i] = (ofm_pair(drive_hi_reg, drive_lo_reg, i) == DRV_CMOS)
                          && (ofm_pair(func_hi_reg, func_lo_reg, i) == FN_GPIO);
      hiz_mask[i] = (ofm_pair(drive_hi_reg, drive_lo_reg, i) == DRV_HIZ);
      nod_mask[i] = (ofm_pair(drive_hi_reg, drive_lo_reg, i) == DRV_NOD);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_read_setup;
    psel_in && !penable_in && !pwrite_in && ofm_decode(paddr_in) == SEL_LEVEL;
  endsequence

  sequence s_read_access;
    psel_in && penable_in && !pwrite_in;
  endsequence

  property p_level_write;
    wr_lane0 && sel == SEL_LEVEL |=> level_reg == $past(pwdata_in[3:0]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("Output level register missed a write");

  property p_pin_follows_level;
    (((pin_level_out ^ level_reg) & cmos_gpio_mask) == 4'h0)
      && ((pin_oe_out & cmos_gpio_mask) == cmos_gpio_mask);
  endproperty
  a_pin_follows_level: assert property (p_pin_follows_level)
    else $error("CMOS general pin does not follow level register");

  property p_readback;
    s_read_setup ##1 s_read_access |-> prdata_out == {28'h000_0000, level_reg};
  endproperty
  a_readback: assert property (p_readback)
    else $error("Level readback differs from written value");

  property p_reserved_zero;
    (s_read_access and (sel != SEL_DRIVE_LO)) |-> prdata_out[31:4] == 28'h000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved read bits not zero");

  property p_hiz_off;
    (pin_oe_out & hiz_mask) == 4'h0;
  endproperty
  a_hiz_off: assert property (p_hiz_off)
    else $error("High impedance pin is driven");

  property p_nod_sinks;
    ((pin_oe_out & nod_mask) == (~pin_src & nod_mask))
      && ((pin_level_out & nod_mask) == 4'h0);
  endproperty
  a_nod_sinks: assert property (p_nod_sinks)
    else $error("N open drain pin drives wrongly");

  property p_reset_values;
    disable iff (1'b0) reset_in |=> drive_lo_reg == 4'h0 && drive_hi_reg == 4'h0
      && func_lo_reg == 4'h0 && func_hi_reg == 4'h0 && pin_oe_out == 4'h0;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Control registers not cleared by reset");

  property p_pin3_timer;
    {func_hi_reg[3], func_lo_reg[3]} == FN_ALT_B |-> pin_src[3] == timer_b_in;
  endproperty
  a_pin3_timer: assert property (p_pin3_timer)
    else $error("Pin 3 not routed to timer B");

  property p_pin2_timer;
    {func_hi_reg[2], func_lo_reg[2]} == FN_ALT_B |-> pin_src[2] == timer_nine_in;
  endproperty
  a_pin2_timer: assert property (p_pin2_timer)
    else $error("Pin 2 not routed to timer nine");

  property p_pin1_route;
    ({func_hi_reg[1], func_lo_reg[1]} == FN_ALT_A |-> pin_src[1] == fast_clock_in)
      and ({func_hi_reg[1], func_lo_reg[1]} == FN_ALT_B |-> pin_src[1] == pwm_channel_b_in);
  endproperty
  a_pin1_route: assert property (p_pin1_route)
    else $error("Pin 1 function routing wrong");

  property p_pin0_route;
    ({func_hi_reg[0], func_lo_reg[0]} == FN_ALT_A |-> pin_src[0] == slow_clock_in)
      and ({func_hi_reg[0], func_lo_reg[0]} == FN_ALT_B |-> pin_src[0] == pwm_channel_a_in);
  endproperty
  a_pin0_route: assert property (p_pin0_route)
    else $error("Pin 0 function routing wrong");

  property p_word_write;
    wr_lane1 && sel == SEL_DRIVE_LO |=> drive_hi_reg == $past(pwdata_in[11:8]);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("16-bit write missed the high drive register");

  // Registers must not move past the access edge of a refused transfer
  property p_unmapped_err;
    psel_in && !penable_in && ofm_decode(paddr_in) == SEL_NONE ##1 psel_in && penable_in
      |-> pslverr_out ##1 $stable({level_reg, drive_lo_reg, drive_hi_reg, func_lo_reg,
                                   func_hi_reg});
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("Unmapped access not flagged");

endmodule : ofm_output_port

/* File: ofm_pkg.sv */
package ofm_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PIN_COUNT = 4;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_LEVEL = 16'hF210;
  localparam logic [15:0] IDX_DRIVE_LO = 16'hF212;
  localparam logic [15:0] IDX_DRIVE_HI = 16'hF213;
  localparam logic [15:0] IDX_FUNC_LO = 16'hF214;
  localparam logic [15:0] IDX_FUNC_HI = 16'hF215;

  // Field positions
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 3;
  localparam int HI_LANE_LSB = 8;
  localparam int HI_LANE_MSB = 11;

  // Reset values
  localparam logic [3:0] RST_LEVEL = 4'h0;
  localparam logic [3:0] RST_DRIVE = 4'h0;
  localparam logic [3:0] RST_FUNC = 4'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    DRV_HIZ = 2'b00,
    DRV_POD = 2'b01,
    DRV_NOD = 2'b10,
    DRV_CMOS = 2'b11
  } ofm_drive_t;

  typedef enum logic [1:0] {
    FN_GPIO = 2'b00,
    FN_ALT_A = 2'b01,
    FN_ALT_B = 2'b10,
    FN_BAD = 2'b11
  } ofm_func_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_LEVEL = 3'b001,
    SEL_DRIVE_LO = 3'b011,
    SEL_DRIVE_HI = 3'b010,
    SEL_FUNC_LO = 3'b110,
    SEL_FUNC_HI = 3'b111
  } ofm_sel_t;

  function automatic ofm_sel_t ofm_decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[17:2];
    if (addr[1:0] != 2'b00 || addr[ADDR_W-1:18] != '0) begin
      return SEL_NONE;
    end else if (idx == IDX_LEVEL) begin
      return SEL_LEVEL;
    end else if (idx == IDX_DRIVE_LO) begin
      return SEL_DRIVE_LO;
    end else if (idx == IDX_DRIVE_HI) begin
      return SEL_DRIVE_HI;
    end else if (idx == IDX_FUNC_LO) begin
      return SEL_FUNC_LO;
    end else if (idx == IDX_FUNC_HI) begin
      return SEL_FUNC_HI;
    end else begin
      return SEL_NONE;
    end
  endfunction : ofm_decode

  function automatic logic [1:0] ofm_pair(input logic [3:0] hi, input logic [3:0] lo,
                                          input int pin);
    return {hi[pin], lo[pin]};
  endfunction : ofm_pair

endpackage : ofm_pkg

/* File: ofm_func_mux.sv */
`timescale 1ns/100ps
module ofm_func_mux
  import ofm_pkg::*;
(
  // Selection
  input wire logic [3:0] func_lo_in,
  input wire logic [3:0] func_hi_in,
  input wire logic [3:0] level_in,
  // Peripheral sources
  input wire logic slow_clock_in,
  input wire logic fast_clock_in,
  input wire logic timer_nine_in,
  input wire logic timer_b_in,
  input wire logic pwm_channel_a_in,
  input wire logic pwm_channel_b_in,
  // Per-pin source
  output logic [3:0] pin_src_out
);

  logic [3:0] alt_a;
  logic [3:0] alt_b;

  always_comb begin
    alt_a = {level_in[3], level_in[2], fast_clock_in, slow_clock_in};
    alt_b = {timer_b_in, timer_nine_in, pwm_channel_b_in, pwm_channel_a_in};
    for (int i = 0; i < PIN_COUNT; i++) begin
      // Prohibited codes fall back to the port level
      case (ofm_func_t'(ofm_pair(func_hi_in, func_lo_in, i)))
        FN_ALT_A: pin_src_out[i] = alt_a[i];
        FN_ALT_B: pin_src_out[i] = alt_b[i];
        default: pin_src_out[i] = level_in[i];
      endcase
    end
  end

endmodule : ofm_func_mux

/* File: ofm_pin_stage.sv */
`timescale 1ns/100ps
module ofm_pin_stage
  import ofm_pkg::*;
(
  // Drive configuration
  input wire logic [3:0] drive_lo_in,
  input wire logic [3:0] drive_hi_in,
  input wire logic [3:0] pin_src_in,
  // Pads, output only
  output logic [3:0] pin_level_out,
  output logic [3:0] pin_oe_out
);

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_level_out[i] = pin_src_in[i];
      case (ofm_drive_t'(ofm_pair(drive_hi_in, drive_lo_in, i)))
        DRV_POD: pin_oe_out[i] = pin_src_in[i];
        DRV_NOD: pin_oe_out[i] = ~pin_src_in[i];
        DRV_CMOS: pin_oe_out[i] = 1'b1;
        default: pin_oe_out[i] = 1'b0;
      endcase
      // Never sensed: the pads have no input path
      if (!pin_oe_out[i]) begin
        pin_level_out[i] = 1'b0;
      end
    end
  end

endmodule : ofm_pin_stage

/* File: ofm_dummy_unused.sv */
`timescale 1ns/100ps

/* File: ofm_led_load.sv */
`timescale 1ns/100ps
module ofm_led_load (
  // Pad drive from the port
  input wire logic [3:0] pin_level_in,
  input wire logic [3:0] pin_oe_in,
  // Resolved pad level
  output logic [3:0] pad_out
);
  // LED to supply pulls an undriven pad high; load never drives back
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_out[i] = pin_oe_in[i] ? pin_level_in[i] : 1'b1;
    end
  end
endmodule : ofm_led_load

/* File: ofm_output_port_test.sv */
`timescale 1ns/100ps
module ofm_output_port_test;
  import ofm_pkg::*;
  localparam logic [31:0] A_LEVEL = 32'h0003_C840;
  localparam logic [31:0] A_DRV_LO = 32'h0003_C848;
  localparam logic [31:0] A_DRV_HI = 32'h0003_C84C;
  localparam logic [31:0] A_FN_LO = 32'h0003_C850;
  localparam logic [31:0] A_FN_HI = 32'h0003_C854;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Sources: slow, fast, timer nine, timer b, pwm a, pwm b
  logic [5:0] src = '0;
  logic [3:0] pin_level;
  logic [3:0] pin_oe;
  logic [3:0] pad;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checks_done = 0;

  ofm_output_port dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .slow_clock_in(src[0]), .fast_clock_in(src[1]), .timer_nine_in(src[2]),
    .timer_b_in(src[3]), .pwm_channel_a_in(src[4]), .pwm_channel_b_in(src[5]),
    .pin_level_out(pin_level), .pin_oe_out(pin_oe)
  );
  ofm_led_load load (.pin_level_in(pin_level), .pin_oe_in(pin_oe), .pad_out(pad));

  initial begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                     input logic [3:0] strb);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    pstrb <= strb;
    @(posedge core_clk_in);
    penable <= 1'b1;
    @(posedge core_clk_in);
    while (pready !== 1'b1) begin
      @(posedge core_clk_in);
    end
    // Answer taken at the edge that samples pready high
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string name, input logic [31:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000, 4'hF);
    check(name, rd, exp);
    check("slave error", {31'h0, er}, 32'h0000_0000);
  endtask : rdchk

  task automatic pins(input logic [3:0] oe, input logic [3:0] lvl);
    @(negedge core_clk_in);
    check("pin oe", {28'h0, pin_oe}, {28'h0, oe});
    check("pin level", {28'h0, pin_level}, {28'h0, lvl & oe});
    check("pad", {28'h0, pad}, {28'h0, (oe & lvl) | ~oe});
  endtask : pins

  // Expected pin source per function code, from the routing rules
  function automatic logic [3:0] route(input logic [1:0] c, input logic [5:0] s,
                                       input logic [3:0] lv);
    logic [3:0] r;
    r = lv;
    if (c == 2'b01) begin
      r[1:0] = s[1:0];
    end else if (c == 2'b10) begin
      r = {s[3], s[2], s[5], s[4]};
    end
    return r;
  endfunction : route

  task automatic test_reset();
    rdchk("level", A_LEVEL, 32'h0000_0000);
    rdchk("drive lo", A_DRV_LO, 32'h0000_0000);
    rdchk("drive hi", A_DRV_HI, 32'h0000_0000);
    rdchk("func lo", A_FN_LO, 32'h0000_0000);
    rdchk("func hi", A_FN_HI, 32'h0000_0000);
    pins(4'h0, 4'h0);
  endtask : test_reset

  task automatic test_level();
    // Both drive registers in one 16-bit access
    apb(1'b1, A_DRV_LO, 32'hFFFF_0F0F, 4'b0011);
    rdchk("drive hi", A_DRV_HI, 32'h0000_000F);
    apb(1'b1, A_LEVEL, 32'hFFFF_FFA5, 4'hF);
    rdchk("level", A_LEVEL, 32'h0000_0005);
    pins(4'hF, 4'h5);
    apb(1'b1, A_LEVEL, 32'h0000_000A, 4'hF);
    pins(4'hF, 4'hA);
  endtask : test_level

  task automatic test_drive();
    logic [3:0] s;
    logic [3:0] oe;
    logic [31:0] w;
    s = 4'b0110;
    apb(1'b1, A_LEVEL, {28'h0, s}, 4'hF);
    for (int d = 0; d < 4; d++) begin
      w = {20'h0, {4{d[1]}}, 4'h0, {4{d[0]}}};
      apb(1'b1, A_DRV_LO, w, 4'b0011);
      rdchk("drive word", A_DRV_LO, w);
      case (d)
        0: oe = 4'h0;
        1: oe = s;
        2: oe = ~s;
        default: oe = 4'hF;
      endcase
      // Open drain N mode is the LED sink setting
      pins(oe, (d == 2) ? 4'h0 : s);
    end
  endtask : test_drive

  task automatic test_func();
    logic [1:0] c;
    logic [5:0] pat;
    apb(1'b1, A_DRV_LO, 32'h0000_0F0F, 4'b0011);
    // Mixed patterns so that a swapped source shows up
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: pat = 6'h00;
        1: pat = 6'h3F;
        2: pat = 6'h25;
        default: pat = 6'h1A;
      endcase
      @(posedge core_clk_in);
      src <= pat;
      apb(1'b1, A_LEVEL, {28'h0, ~pat[3:0]}, 4'hF);
      for (int k = 0; k < 4; k++) begin
        c = k[1:0];
        apb(1'b1, A_FN_LO, {28'h0, {4{c[0]}}}, 4'hF);
        apb(1'b1, A_FN_HI, {28'h0, {4{c[1]}}}, 4'hF);
        rdchk("func hi", A_FN_HI, {28'h0, {4{c[1]}}});
        pins(4'hF, route(c, pat, ~pat[3:0]));
      end
    end
  endtask : test_func

  task automatic test_unmapped();
    apb(1'b1, A_LEVEL, 32'h0000_0003, 4'hF);
    // Where a direction register would sit
    apb(1'b1, 32'h0003_C844, 32'h0000_000F, 4'hF);
    check("unmapped err", {31'h0, er}, 32'h0000_0001);
    apb(1'b0, 32'h0003_C844, 32'h0000_0000, 4'hF);
    check("unmapped rd", rd, 32'h0000_0000);
    check("unmapped rd err", {31'h0, er}, 32'h0000_0001);
    apb(1'b1, 32'h0003_C841, 32'h0000_000C, 4'hF);
    check("misaligned err", {31'h0, er}, 32'h0000_0001);
    // Low lane strobe off: the level register must keep its value
    apb(1'b1, A_LEVEL, 32'h0000_000C, 4'h0);
    check("strobe off err", {31'h0, er}, 32'h0000_0000);
    rdchk("level", A_LEVEL, 32'h0000_0003);
  endtask : test_unmapped

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    test_reset();
    test_level();
    test_drive();
    test_func();
    test_unmapped();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_count++;
    summarize();
  end
endmodule : ofm_output_port_test
